//--- verilog/ivfs_pkg.sv
// Purpose: shared constants, types and helpers for the input rail supervisor
// Assumes: voltages arrive as unsigned counts of 0.25 V
// Notes:   limit words use the signed linear word format
package ivfs_pkg;

  localparam int N_PHASE = 4;
  localparam int PAGE_W  = 2;
  localparam int QV_W    = 12;

  // command codes
  localparam logic [7:0] CMD_CLEAR    = 8'h03;
  localparam logic [7:0] CMD_OV_LIM   = 8'h55;
  localparam logic [7:0] CMD_OV_POL   = 8'h56;
  localparam logic [7:0] CMD_UV_LIM   = 8'h58;
  localparam logic [7:0] CMD_ST_BYTE  = 8'h78;
  localparam logic [7:0] CMD_ST_WORD  = 8'h79;
  localparam logic [7:0] CMD_ST_INPUT = 8'h7C;
  localparam logic [7:0] CMD_ST_CML   = 8'h7E;

  // linear word layout and reset contents
  localparam int EXP_MSB = 15;
  localparam int EXP_LSB = 11;
  localparam int MAN_MSB = 10;
  localparam int QV_FRAC = 2;
  localparam logic [4:0]  LIN_EXP_RESET = 5'h1E;
  localparam logic [10:0] OV_MAN_RESET  = 11'h050;
  localparam logic [10:0] UV_MAN_RESET  = 11'h00A;
  localparam logic [7:0]  POLICY_RESET  = 8'h80;

  // supported ranges in 0.25 V counts
  localparam logic [QV_W-1:0] LIM_MIN_QV = 12'h014;
  localparam logic [QV_W-1:0] LIM_MAX_QV = 12'h058;
  localparam logic [QV_W-1:0] QV_SAT     = 12'hFFF;

  // policy byte fields
  localparam int ACT_MSB = 7;
  localparam int ACT_LSB = 6;
  localparam int RTY_MSB = 5;
  localparam int RTY_LSB = 3;
  localparam int DLY_MSB = 2;
  localparam int DLY_LSB = 0;
  localparam logic [1:0] ACT_IGNORE    = 2'h0;
  localparam logic [1:0] ACT_DELAYED   = 2'h1;
  localparam logic [1:0] ACT_IMMEDIATE = 2'h2;
  localparam logic [1:0] ACT_INVALID   = 2'h3;
  localparam logic [2:0] RETRY_NONE    = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  localparam logic [2:0] DLY_SHORT_MAX = 3'h1;
  localparam logic [2:0] DLY_MID_MAX   = 3'h4;
  localparam logic [3:0] CYC_SHORT     = 4'h3;
  localparam logic [3:0] CYC_MID       = 4'h5;
  localparam logic [3:0] CYC_LONG      = 4'h9;

  // status bit positions
  localparam int SB_NOTA     = 0;
  localparam int SB_CML      = 1;
  localparam int SW_INPUT    = 13;
  localparam int SI_OV       = 7;
  localparam int SI_UVW      = 5;
  localparam int SC_INV_CMD  = 7;
  localparam int SC_INV_DATA = 6;

  typedef enum logic [2:0] {ST_OFF, ST_RUN, ST_DELAY, ST_WAIT, ST_LATCH} ovf_state_t;

  typedef struct packed {
    ovf_state_t st;
    logic [3:0] cyc;
    logic [2:0] waits;
    logic [2:0] tries;
  } ovf_fsm_t;

  typedef struct packed {
    logic [15:0]                 ov_word;
    logic [7:0]                  policy;
    logic [N_PHASE-1:0][15:0]    uv_word;
    logic [2:0]                  en_sync;
    logic                        en;
    logic                        ov_prev;
    logic [N_PHASE-1:0]          uv_prev;
    logic                        st_ov;
    logic                        st_uvw;
    logic [N_PHASE-1:0]          uvw_flag;
    logic                        cml_cmd;
    logic                        cml_data;
    logic [15:0]                 rdata;
    logic                        rvalid;
  } sup_state_t;

  // shutdown delay in switching cycles
  function automatic logic [3:0] delay_cycles(input logic [2:0] d);
    if (d <= DLY_SHORT_MAX) return CYC_SHORT;
    else if (d <= DLY_MID_MAX) return CYC_MID;
    else return CYC_LONG;
  endfunction : delay_cycles

  // restart wait in soft-start ramp times
  function automatic logic [2:0] restart_wait_period_mult(input logic [2:0] d);
    return (d <= DLY_SHORT_MAX) ? 3'h1 : d;
  endfunction : restart_wait_period_mult

  // linear word to rounded 0.25 V counts; msb set when non-negative and no fraction bits are lost
  function automatic logic [QV_W:0] lin_to_qv(input logic [15:0] w);
    logic signed [5:0] e;
    logic [26:0]       big;
    logic [QV_W-1:0]   v;
    logic              ex;
    int                sh;
    e   = $signed({w[EXP_MSB], w[EXP_MSB:EXP_LSB]}) + 6'(QV_FRAC);
    big = 27'(w[MAN_MSB-1:0]);
    v   = '0;
    ex  = 1'b0;
    sh  = 0;
    if (w[MAN_MSB]) begin
      v  = '0;
      ex = 1'b0;
    end else if (e >= 6'sd0) begin
      ex = 1'b1;
      if (e > 6'sd12) v = QV_SAT;
      else begin
        big = big << e;
        v   = (|big[26:QV_W]) ? QV_SAT : big[QV_W-1:0];
      end
    end else begin
      sh  = int'(-e);
      ex  = (big & ((27'd1 << sh) - 27'd1)) == 27'd0;
      big = (big + (27'd1 << (sh - 1))) >> sh;
      v   = big[QV_W-1:0];
    end
    return {ex, v};
  endfunction : lin_to_qv

endpackage : ivfs_pkg

//--- verilog/ovf_if.sv
// Purpose: link between the supervisor core and its fault response sequencer
// Assumes: all signals on mclk_i
// Notes:   ctl side drives policy and conditions, fsm side drives power state
`timescale 1ns/1ps
interface ovf_if;
  logic       ov_level;
  logic       en;
  logic       pwm_tick;
  logic       ramp_tick;
  logic [1:0] action;
  logic [2:0] retry;
  logic [2:0] dly;
  logic       switching;
  logic       latched;
  modport ctl (output ov_level, en, pwm_tick, ramp_tick, action, retry, dly,
               input switching, latched);
  modport fsm (input ov_level, en, pwm_tick, ramp_tick, action, retry, dly,
               output switching, latched);
endinterface : ovf_if

//--- verilog/ovf_response.sv
// Purpose: overvoltage response sequencer: ignore, delayed or immediate stop, retries
// Assumes: pwm_tick one pulse per switching cycle, ramp_tick one per ramp time
// Notes:   enable low returns to off from any state
`timescale 1ns/1ps
module ovf_response import ivfs_pkg::*; (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // sequencer link
  ovf_if.fsm       bus
);

  ovf_fsm_t s;
  ovf_fsm_t next_s;
  logic     shut;

  always_comb begin
    next_s = s;
    shut   = 1'b0;
    if (!bus.en) begin
      next_s.st    = ST_OFF;
      next_s.tries = 3'h0;
    end else begin
      case (s.st)
        ST_OFF: begin
          if (!bus.ov_level) next_s.st = ST_RUN;
        end
        ST_RUN: begin
          if (bus.ov_level) begin
            case (bus.action)
              ACT_DELAYED: begin
                next_s.st  = ST_DELAY;
                next_s.cyc = 4'h0;
              end
              ACT_IMMEDIATE: shut = 1'b1;
              default: ;
            endcase
          end
        end
        ST_DELAY: begin
          if (bus.pwm_tick) begin
            if (s.cyc + 4'h1 == delay_cycles(bus.dly)) begin
              if (bus.ov_level) shut = 1'b1;
              else next_s.st = ST_RUN;
            end else begin
              next_s.cyc = s.cyc + 4'h1;
            end
          end
        end
        ST_WAIT: begin
          if (bus.ramp_tick) begin
            if (s.waits + 3'h1 == restart_wait_period_mult(bus.dly)) begin
              next_s.waits = 3'h0;
              if (bus.ov_level) begin
                if (bus.retry != RETRY_FOREVER && s.tries + 3'h1 >= bus.retry) begin
                  next_s.st = ST_LATCH;
                end else if (bus.retry != RETRY_FOREVER) begin
                  next_s.tries = s.tries + 3'h1;
                end
              end else begin
                next_s.st    = ST_RUN;
                next_s.tries = 3'h0;
              end
            end else begin
              next_s.waits = s.waits + 3'h1;
            end
          end
        end
        ST_LATCH: ;
        default: next_s.st = ST_OFF;
      endcase
    end
    if (shut) begin
      next_s.st    = (bus.retry == RETRY_NONE) ? ST_LATCH : ST_WAIT;
      next_s.waits = 3'h0;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) s <= '{st: ST_OFF, cyc: 4'h0, waits: 3'h0, tries: 3'h0};
    else s <= next_s;
  end

  assign bus.switching = (s.st == ST_RUN) || (s.st == ST_DELAY);
  assign bus.latched   = (s.st == ST_LATCH);

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  sequence run_sees_ov(logic [1:0] act);
    s.st == ST_RUN && bus.en && bus.ov_level && bus.action == act;
  endsequence

  a_ignore_keeps_run: assert property (run_sees_ov(ACT_IGNORE) |=> bus.switching)
    else $error("ignore policy interrupted switching");
  a_delay_holds_on: assert property (run_sees_ov(ACT_DELAYED) |=>
                                     (bus.switching || !bus.en)[*3])
    else $error("delayed policy stopped before three cycles");
  a_immediate_stop: assert property (run_sees_ov(ACT_IMMEDIATE) |=> !bus.switching)
    else $error("immediate policy kept switching");
  a_zero_retry_latch: assert property (run_sees_ov(ACT_IMMEDIATE) && bus.retry == RETRY_NONE
                                       |=> bus.latched)
    else $error("zero retry did not latch off");
  a_refuse_start: assert property (s.st == ST_OFF && bus.ov_level |=> !bus.switching)
    else $error("started with overvoltage present");

endmodule : ovf_response

//--- verilog/input_voltage_fault_supervisor.sv
// Purpose: input rail overvoltage fault and undervoltage warning supervisor
// Assumes: vin samples and ticks come from logic on mclk_i; enable is a pin
// Notes:   commands use a one-cycle strobe; read data valid one cycle later
`timescale 1ns/1ps

module input_voltage_fault_supervisor import ivfs_pkg::*; (
  // clock and reset
  input  wire logic                            mclk_i,
  input  wire logic                            rstn_i,
  // command port
  input  wire logic                            cmd_wr_i,
  input  wire logic                            cmd_rd_i,
  input  wire logic [7:0]                      cmd_code_i,
  input  wire logic [PAGE_W-1:0]               cmd_page_i,
  input  wire logic [15:0]                     cmd_wdata_i,
  output logic      [15:0]                     cmd_rdata_o,
  output logic                                 cmd_rvalid_o,
  // rail measurement and timing
  input  wire logic [N_PHASE-1:0][QV_W-1:0]    vin_phase_i,
  input  wire logic                            pwm_tick_i,
  input  wire logic                            ramp_tick_i,
  input  wire logic                            restore_i,
  input  wire logic                            enable_pin_i,
  // status and power control
  output logic                                 switching_o,
  output logic                                 latched_off_o,
  output logic                                 input_overvolt_event_o,
  output logic      [N_PHASE-1:0]              input_undervolt_warning_flag_o,
  output logic                                 alert_n_o
);

  sup_state_t               s;
  sup_state_t               next_s;
  ovf_if                    ovb ();

  logic [QV_W:0]            ov_dec;
  logic [QV_W:0]            wr_dec;
  logic [QV_W-1:0]          ov_qv;
  logic [QV_W-1:0]          rs_qv;
  logic                     ov_lvl;
  logic                     ov_rise;
  logic [N_PHASE-1:0]       uv_lvl;
  logic [N_PHASE-1:0][QV_W:0] uv_dec;
  logic [N_PHASE-1:0]       uv_rise;
  logic                     wr_in_range;
  logic [7:0]               st_byte;
  logic [7:0]               st_input;
  logic [7:0]               st_cml;
  logic [1:0]               wr_act;

  // decode of stored and incoming limits
  assign ov_dec      = lin_to_qv(s.ov_word);
  assign ov_qv       = ov_dec[QV_W-1:0];
  assign wr_dec      = lin_to_qv(cmd_wdata_i);
  assign wr_in_range = wr_dec[QV_W] && wr_dec[QV_W-1:0] >= LIM_MIN_QV
                       && wr_dec[QV_W-1:0] <= LIM_MAX_QV;
  assign wr_act      = cmd_wdata_i[ACT_MSB:ACT_LSB];

  // nearest supported value for restore
  always_comb begin
    if (ov_qv < LIM_MIN_QV) rs_qv = LIM_MIN_QV;
    else if (ov_qv > LIM_MAX_QV) rs_qv = LIM_MAX_QV;
    else rs_qv = ov_qv;
  end

  // continuous comparison, edge qualified
  assign ov_lvl  = vin_phase_i[0] >= ov_qv;
  assign ov_rise = ov_lvl && !s.ov_prev;

  always_comb begin
    for (int p = 0; p < N_PHASE; p++) begin
      uv_dec[p] = lin_to_qv(s.uv_word[p]);
      uv_lvl[p] = vin_phase_i[p] < uv_dec[p][QV_W-1:0];
    end
  end
  assign uv_rise = uv_lvl & ~s.uv_prev;

  // status views
  always_comb begin
    st_byte              = 8'h00;
    st_byte[SB_NOTA]     = s.st_ov || s.st_uvw;
    st_byte[SB_CML]      = s.cml_cmd || s.cml_data;
    st_input             = 8'h00;
    st_input[SI_OV]      = s.st_ov;
    st_input[SI_UVW]     = s.st_uvw;
    st_cml               = 8'h00;
    st_cml[SC_INV_CMD]   = s.cml_cmd;
    st_cml[SC_INV_DATA]  = s.cml_data;
  end

  always_comb begin
    next_s          = s;
    next_s.rvalid   = 1'b0;
    next_s.en_sync  = {s.en_sync[1:0], enable_pin_i};
    if (s.en_sync[1] == s.en_sync[2]) next_s.en = s.en_sync[2];
    next_s.ov_prev  = ov_lvl;
    next_s.uv_prev  = uv_lvl;

    if (restore_i) begin
      next_s.ov_word = {LIN_EXP_RESET, 11'(rs_qv)};
    end

    // clears first so that a same-cycle event still sets
    if (cmd_wr_i) begin
      case (cmd_code_i)
        CMD_CLEAR: begin
          next_s.st_ov    = 1'b0;
          next_s.st_uvw   = 1'b0;
          next_s.uvw_flag = '0;
          next_s.cml_cmd  = 1'b0;
          next_s.cml_data = 1'b0;
        end
        CMD_OV_LIM: begin
          if (wr_in_range) next_s.ov_word = cmd_wdata_i;
          else next_s.cml_data = 1'b1;
        end
        CMD_OV_POL: begin
          if (wr_act == ACT_INVALID || |cmd_wdata_i[15:8]) begin
            next_s.cml_data = 1'b1;
          end else begin
            next_s.policy = cmd_wdata_i[7:0];
          end
        end
        CMD_UV_LIM: begin
          if (wr_in_range) next_s.uv_word[cmd_page_i] = cmd_wdata_i;
          else next_s.cml_data = 1'b1;
        end
        default: next_s.cml_cmd = 1'b1;
      endcase
    end

    if (cmd_rd_i) begin
      next_s.rvalid = 1'b1;
      case (cmd_code_i)
        CMD_OV_LIM:   next_s.rdata = s.ov_word;
        CMD_OV_POL:   next_s.rdata = {8'h00, s.policy};
        CMD_UV_LIM:   next_s.rdata = s.uv_word[cmd_page_i];
        CMD_ST_BYTE:  next_s.rdata = {8'h00, st_byte};
        CMD_ST_WORD: begin
          next_s.rdata           = {8'h00, st_byte};
          next_s.rdata[SW_INPUT] = s.st_ov || s.st_uvw;
        end
        CMD_ST_INPUT: next_s.rdata = {8'h00, st_input};
        CMD_ST_CML:   next_s.rdata = {8'h00, st_cml};
        default: begin
          next_s.rdata   = 16'h0000;
          next_s.cml_cmd = 1'b1;
        end
      endcase
    end

    // events set after clears
    if (ov_rise) next_s.st_ov = 1'b1;
    if (|uv_rise) next_s.st_uvw = 1'b1;
    next_s.uvw_flag = next_s.uvw_flag | uv_rise;
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s          <= '0;
      s.ov_word  <= {LIN_EXP_RESET, OV_MAN_RESET};
      s.policy   <= POLICY_RESET;
      s.uv_word  <= {N_PHASE{LIN_EXP_RESET, UV_MAN_RESET}};
      s.ov_prev  <= 1'b1;
      s.uv_prev  <= '1;
    end else begin
      s <= next_s;
    end
  end

  // response sequencer
  assign ovb.ov_level  = ov_lvl;
  assign ovb.en        = s.en;
  assign ovb.pwm_tick  = pwm_tick_i;
  assign ovb.ramp_tick = ramp_tick_i;
  assign ovb.action    = s.policy[ACT_MSB:ACT_LSB];
  assign ovb.retry     = s.policy[RTY_MSB:RTY_LSB];
  assign ovb.dly       = s.policy[DLY_MSB:DLY_LSB];

  ovf_response u_resp (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .bus    (ovb.fsm)
  );

  assign switching_o                    = ovb.switching;
  assign latched_off_o                  = ovb.latched;
  assign input_overvolt_event_o         = s.st_ov;
  assign input_undervolt_warning_flag_o = s.uvw_flag;
  assign cmd_rdata_o                    = s.rdata;
  assign cmd_rvalid_o                   = s.rvalid;
  assign alert_n_o = !(s.st_ov || s.st_uvw || s.cml_cmd || s.cml_data);

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  sequence bad_policy_write;
    cmd_wr_i && cmd_code_i == CMD_OV_POL && cmd_wdata_i[ACT_MSB:ACT_LSB] == ACT_INVALID;
  endsequence

  a_ov_event_alert: assert property (ov_rise |=> s.st_ov && !alert_n_o
                                     && st_byte[SB_NOTA])
    else $error("overvoltage edge did not set status and alert");
  a_bad_policy_kept: assert property (bad_policy_write |=> s.cml_data && !alert_n_o
                                      && s.policy == $past(s.policy))
    else $error("invalid policy accepted or not flagged");
  a_ov_range_check: assert property (cmd_wr_i && cmd_code_i == CMD_OV_LIM && !wr_in_range
                                     |=> s.cml_data && $stable(s.ov_word))
    else $error("out of range overvoltage limit accepted");
  a_uv_phase_own: assert property (|uv_rise |=> s.st_uvw
                                   && ((s.uvw_flag & $past(uv_rise)) == $past(uv_rise)))
    else $error("phase undervoltage warning not recorded");
  a_uv_floor_kept: assert property (cmd_wr_i && cmd_code_i == CMD_UV_LIM && wr_dec[QV_W]
                                    && wr_dec[QV_W-1:0] < LIM_MIN_QV
                                    |=> s.cml_data && $stable(s.uv_word))
    else $error("undervoltage limit set below floor");
  a_rise_only_once: assert property (ov_rise |=> !ov_rise)
    else $error("overvoltage event repeated on a steady level");

endmodule : input_voltage_fault_supervisor

//--- test/host_model.sv
// Purpose: host side of the supervisor command port
// Assumes: one strobe per command, taken at the edge that sees it high
// Notes:   released code and data lines carry inverted junk so stale values never pass; page holds
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire logic        mclk_i,
  // command port
  input  wire logic [15:0] rdata_i,
  input  wire logic        rvalid_i,
  output logic             wr_o,
  output logic             rd_o,
  output logic [7:0]       code_o,
  output logic [1:0]       page_o,
  output logic [15:0]      wdata_o
);
  initial begin
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    code_o  = 8'h00;
    page_o  = 2'h0;
    wdata_o = 16'h0000;
  end

  // one word per command, strobe held one cycle
  task automatic cmd(input logic w, input logic [7:0] c, input logic [1:0] p,
                     input logic [15:0] d);
    @(posedge mclk_i);
    wr_o    <= w;
    rd_o    <= !w;
    code_o  <= c;
    page_o  <= p;
    wdata_o <= d;
    @(posedge mclk_i);
    wr_o    <= 1'b0;
    rd_o    <= 1'b0;
    code_o  <= ~c;
    wdata_o <= ~d;
  endtask : cmd

  // read data is valid exactly one cycle after the taking edge
  task automatic rd(input logic [7:0] c, input logic [1:0] p, output logic [15:0] q);
    cmd(1'b0, c, p, 16'h0000);
    @(posedge mclk_i);
    q = (rvalid_i === 1'b1) ? rdata_i : 16'hxxxx;
  endtask : rd
endmodule : host_model

//--- test/testbench.sv
// Purpose: self-checking bench for the input rail supervisor
// Assumes: ticks every 4 and 16 cycles, vin in 0.25 V counts
// Notes:   limit of 12 V is programmed before the fault runs
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
  $display("mismatch at %0t got %h exp %h", $time, (a), (b)); end end
module testbench import ivfs_pkg::*;;
  logic                         mclk_i = 1'b0;
  logic                         rstn_i = 1'b0;
  logic                         wr, rd, rvalid, pwm_tick, ramp_tick, en, sw, lat, ovf, alert_n;
  logic [7:0]                   code;
  logic [1:0]                   page;
  logic [15:0]                  wdata, rdata, q;
  logic [N_PHASE-1:0][QV_W-1:0] vin;
  logic [N_PHASE-1:0]           uvf;
  logic [3:0]                   tick_cnt;
  logic                         restore;
  int                           num_errors, checks_done;

  always #20 mclk_i = ~mclk_i;

  always @(posedge mclk_i) begin
    tick_cnt  <= tick_cnt + 4'h1;
    pwm_tick  <= (tick_cnt[1:0] == 2'h0);
    ramp_tick <= (tick_cnt == 4'h0);
  end

  host_model host_model_inst (.mclk_i(mclk_i), .rdata_i(rdata), .rvalid_i(rvalid),
    .wr_o(wr), .rd_o(rd), .code_o(code), .page_o(page), .wdata_o(wdata));

  input_voltage_fault_supervisor input_voltage_fault_supervisor_inst (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .cmd_wr_i(wr), .cmd_rd_i(rd), .cmd_code_i(code),
    .cmd_page_i(page), .cmd_wdata_i(wdata), .cmd_rdata_o(rdata), .cmd_rvalid_o(rvalid),
    .vin_phase_i(vin), .pwm_tick_i(pwm_tick), .ramp_tick_i(ramp_tick), .restore_i(restore),
    .enable_pin_i(en), .switching_o(sw), .latched_off_o(lat),
    .input_overvolt_event_o(ovf), .input_undervolt_warning_flag_o(uvf), .alert_n_o(alert_n));

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  task automatic wait_sw(input logic v, input int n);
    for (int i = 0; i < n && sw !== v; i++) @(posedge mclk_i);
  endtask : wait_sw

  task automatic clear_off;
    en <= 1'b0;
    vin <= {N_PHASE{12'h02c}};
    repeat (6) @(posedge mclk_i);
    host_model_inst.cmd(1'b1, CMD_CLEAR, 2'h0, 16'h0000);
    repeat (2) @(posedge mclk_i);
  endtask : clear_off

  task automatic t_regs;
    logic [7:0]  bad_code [5] = '{CMD_OV_LIM, CMD_OV_LIM, CMD_OV_POL, CMD_OV_POL, CMD_UV_LIM};
    logic [15:0] bad_data [5] = '{16'hf010, 16'hf059, 16'h00c0, 16'h0180, 16'hf010};
    host_model_inst.rd(CMD_OV_LIM, 2'h0, q);
    `CHK(q, 16'hf050)
    host_model_inst.rd(CMD_OV_POL, 2'h0, q);
    `CHK(q[7:0], POLICY_RESET)
    host_model_inst.rd(CMD_UV_LIM, 2'h3, q);
    `CHK(q, 16'hf00a)
    host_model_inst.cmd(1'b1, CMD_OV_LIM, 2'h0, 16'hf030);
    host_model_inst.cmd(1'b1, CMD_UV_LIM, 2'h1, 16'hf028);
    for (int i = 0; i < 5; i++) begin
      host_model_inst.cmd(1'b1, bad_code[i], 2'h1, bad_data[i]);
      host_model_inst.rd(CMD_ST_CML, 2'h0, q);
      `CHK(q[SC_INV_DATA], 1'b1)
      `CHK(alert_n, 1'b0)
      host_model_inst.cmd(1'b1, CMD_CLEAR, 2'h0, 16'h0000);
      @(posedge mclk_i);
      `CHK(alert_n, 1'b1)
    end
    host_model_inst.rd(CMD_OV_LIM, 2'h0, q);
    `CHK(q, 16'hf030)
    host_model_inst.cmd(1'b1, CMD_OV_LIM, 2'h0, 16'he862);
    restore <= 1'b1;
    @(posedge mclk_i);
    restore <= 1'b0;
    host_model_inst.rd(CMD_OV_LIM, 2'h0, q);
    `CHK(q, 16'hf031)
    host_model_inst.cmd(1'b1, CMD_OV_LIM, 2'h0, 16'hf030);
    host_model_inst.rd(CMD_UV_LIM, 2'h1, q);
    `CHK(q, 16'hf028)
    $display("test regs done");
  endtask : t_regs

  task automatic t_start_block;
    host_model_inst.cmd(1'b1, CMD_OV_POL, 2'h0, 16'h0000);
    vin[0] <= 12'h040;
    repeat (3) @(posedge mclk_i);
    `CHK(ovf, 1'b1)
    en <= 1'b1;
    repeat (40) @(posedge mclk_i);
    `CHK(sw, 1'b0)
    clear_off();
    $display("test start block done");
  endtask : t_start_block

  task automatic ov_run(input logic [7:0] pol);
    int cnt;
    int exp_cnt;
    cnt = 0;
    exp_cnt = (pol[2:0] <= 3'h1) ? 3 : (pol[2:0] <= 3'h4) ? 5 : 9;
    host_model_inst.cmd(1'b1, CMD_OV_POL, 2'h0, {8'h00, pol});
    en <= 1'b1;
    wait_sw(1'b1, 60);
    `CHK(sw, 1'b1)
    vin[0] <= 12'h040;
    if (pol[7:6] == ACT_DELAYED) begin
      for (int i = 0; i < 100 && sw === 1'b1; i++) begin
        @(posedge mclk_i);
        if (pwm_tick === 1'b1) cnt++;
      end
      `CHK(cnt >= exp_cnt && cnt <= exp_cnt + 1, 1'b1)
    end else begin
      repeat (2) @(posedge mclk_i);
      `CHK(sw, (pol[7:6] == ACT_IGNORE))
    end
    `CHK(ovf, 1'b1)
    host_model_inst.rd(CMD_ST_INPUT, 2'h0, q);
    `CHK(q[SI_OV], 1'b1)
    host_model_inst.rd(CMD_ST_WORD, 2'h0, q);
    `CHK({q[SW_INPUT], q[SB_NOTA], alert_n}, 3'b110)
    for (int i = 0; i < 180; i++) begin
      @(posedge mclk_i);
      if (sw !== (pol[7:6] == ACT_IGNORE)) cnt = -99;
    end
    `CHK(cnt >= 0, 1'b1)
    `CHK(lat, (pol[7:6] != ACT_IGNORE && pol[5:3] != RETRY_FOREVER))
    vin[0] <= 12'h02c;
    wait_sw(1'b1, 150);
    `CHK(sw, (pol[7:6] == ACT_IGNORE || pol[5:3] == RETRY_FOREVER))
    clear_off();
    $display("test policy %h done", pol);
  endtask : ov_run

  task automatic t_uv;
    host_model_inst.cmd(1'b1, CMD_UV_LIM, 2'h2, 16'hf028);
    vin[2] <= 12'h024;
    repeat (3) @(posedge mclk_i);
    `CHK(uvf, 4'b0100)
    host_model_inst.rd(CMD_ST_INPUT, 2'h0, q);
    `CHK(q[SI_UVW], 1'b1)
    host_model_inst.rd(CMD_ST_BYTE, 2'h0, q);
    `CHK({q[SB_NOTA], alert_n}, 2'b10)
    host_model_inst.cmd(1'b1, CMD_CLEAR, 2'h0, 16'h0000);
    repeat (6) @(posedge mclk_i);
    `CHK({uvf, alert_n}, 5'b0_0001)
    clear_off();
    $display("test uv done");
  endtask : t_uv

  initial begin
    tick_cnt = 4'h0;
    pwm_tick = 1'b0;
    ramp_tick = 1'b0;
    en = 1'b0;
    restore = 1'b0;
    vin = {N_PHASE{12'h02c}};
    repeat (2) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_regs();
    t_start_block();
    ov_run(8'h00);
    ov_run(8'h48);
    ov_run(8'h42);
    ov_run(8'h4d);
    ov_run(8'h89);
    ov_run(8'hb9);
    t_uv();
    final_report();
  end

  initial begin
    #800000;
    num_errors++;
    $display("watchdog expired");
    final_report();
  end
endmodule : testbench
